// *** hw/ees_consts.vh ***
// Constants for the two-wire EEPROM slave write path
`ifndef EES_CONSTS_VH
`define EES_CONSTS_VH

`define EES_PREFIX_MAIN 4'ha
`define EES_PREFIX_SPECIAL 4'hb
`define EES_SEL_RESET 3'h0
`define EES_SWP_RESET 1'h0
`define EES_CFG_SEL_HI 7
`define EES_CFG_SEL_LO 5
`define EES_CFG_SWP 1
`define EES_AREA_HI 2
`define EES_AREA_LO 1
`define EES_AREA_SECURE 2'h0
`define EES_AREA_UID 2'h1
`define EES_AREA_LOCK 2'h2
`define EES_AREA_CFG 2'h3
`define EES_LOCK_DATA 8'hff
`define EES_MAIN_ADDR_W 13
`define EES_PAGE_OFS_W 5
`define EES_SEC_OFS_W 6
`define EES_BITS_LAST 4'h7
`define EES_BITS_ACK 4'h8
`define EES_BITS_DONE 4'h9
`define EES_TWR_MS 5
`define EES_CLK_HZ 20000000

`endif

// *** hw/ees_sync.v ***
// Two-flop synchroniser for the bus pins
`timescale 1ns/100ps
`default_nettype none

module ees_sync
(
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Signals
  input wire d,
  output reg q
);

  reg meta;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta <= 1'b1;
      q <= 1'b1;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// *** hw/ees_write_timer.v ***
// Internal write cycle timer
`timescale 1ns/100ps
`default_nettype none

module ees_write_timer
#(
  parameter WRITE_CYCLES = 100000
)
(
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Control
  input wire start,
  output wire busy
);

  reg [16:0] count;

  assign busy = (count != 17'h0);

  always @(posedge sys_clk)
  begin
    if (rst)
      count <= 17'h0;
    else if (start)
      count <= WRITE_CYCLES[16:0];
    else if (busy)
      count <= count - 17'h1;
  end

endmodule

`default_nettype wire

// *** hw/ees_slave.v ***
// Two-wire EEPROM slave front end, write path
// Behaviour
// [RL1] Power-on reset returns logic to standby
// [RL2] Sample on SCL rise, change after fall
// [RL3] Open drain: drive low only, release for one
// [RL4] SDA fall/rise while SCL high: START/STOP
// [RL5] Ignore everything until a START is seen
// [RL6] Master keeps SDA stable while SCL high
// [RL7] Address: prefix, three select bits, direction
// [RL8] Device select defaults to zero
// [RL9] Acknowledge matching address on ninth clock
// [RL10] Write bytes acked only if not protected
// [RL11] Transmitter releases SDA on ninth clock
// [RL12] Byte write; STOP launches internal write
// [RL13] No acknowledge while internal write runs
// [RL14] Poll by address; ack once write completes
// [RL15] Master waits full time after config write
// [RL16] 256 pages of 32 bytes, one-cycle commit
// [RL17] Page fixed, in-page counter increments
// [RL18] In-page counter wraps; write after STOP
// [RL19] Secure write: special prefix, area pattern 00
// [RL20] Secure offset uses low six bits
// [RL21] Lock: pattern 10, data byte all ones
// [RL22] Locked secure page refuses all writes
// [RL23] Master starts only on an idle bus
// [RL24] Config: select in b7..b5, protect in b1
// [RL25] Protect blocks writes except clearing itself
`timescale 1ns/100ps
`default_nettype none
`include "ees_consts.vh"

module ees_slave
#(
  parameter WRITE_CYCLES = (`EES_CLK_HZ / 1000) * `EES_TWR_MS
)
(
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Two-wire bus
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Memory write port
  output reg mem_wr,
  output reg mem_secure,
  output reg [12:0] mem_addr,
  output reg [7:0] mem_data,
  // Commit and status
  output reg commit,
  output wire busy,
  output reg [2:0] dev_select,
  output reg soft_write_protect,
  output reg secure_locked
);

  // ****************************************
  // Pin sampling
  // ****************************************
  wire scl;
  wire sda;
  reg scl_d;
  reg sda_d;

  ees_sync u_scl
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(scl_in),
    .q(scl)
  );

  ees_sync u_sda
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(sda_in),
    .q(sda)
  );

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  wire scl_rise = scl & ~scl_d; // RL2
  wire scl_fall = ~scl & scl_d; // RL2
  // Both conditions need SCL high on two samples, so a data
  // change next to an SCL edge is never taken for one
  wire start_cond = scl & scl_d & sda_d & ~sda; // RL4
  wire stop_cond = scl & scl_d & ~sda_d & sda; // RL4

  // ****************************************
  // Internal write timer
  // ****************************************
  reg launch;

  // Milliseconds in silicon; the bench shortens it
  ees_write_timer #(.WRITE_CYCLES(WRITE_CYCLES)) u_timer
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(launch),
    .busy(busy)
  );

  // ****************************************
  // Transfer state
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_DEVADDR = 3'h1;
  localparam ST_ADDR_HI = 3'h2;
  localparam ST_ADDR_LO = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_READ = 3'h5;

  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg ack_due;
  reg ack_drive;
  reg special;
  reg [1:0] area;
  reg [7:0] addr_hi;
  reg [5:0] offset;
  reg pending;
  reg pend_cfg;
  reg pend_lock;
  reg [7:0] cfg_data;

  // Byte just completed with the latest bit folded in
  wire [7:0] byte_in = {shift[6:0], sda};
  // Count runs 0..7 for data, 8 in the ninth clock's low phase
  // and 9 from its rise to its fall
  wire in_ack_slot = (bit_cnt == `EES_BITS_ACK);
  wire in_done_slot = (bit_cnt == `EES_BITS_DONE);

  // Open drain: only ever pull low
  assign sda_out = 1'b0; // RL3
  assign sda_oe = ack_drive; // RL3

  // Write permission for the location addressed so far
  reg allowed;
  always @*
  begin
    allowed = 1'b1;
    if (!special)
      allowed = ~soft_write_protect; // RL25
    else if (area == `EES_AREA_SECURE)
      allowed = ~soft_write_protect & ~secure_locked; // RL22
    else if (area == `EES_AREA_LOCK)
      allowed = ~soft_write_protect & ~secure_locked; // RL25
    else if (area == `EES_AREA_CFG)
      allowed = 1'b1; // Protect bit may still be cleared
    else
      allowed = 1'b0; // Identity area is read-only
  end

  // ****************************************
  // Byte engine
  // ****************************************
  always @(posedge sys_clk)
  begin
    if (rst)
    begin // RL1
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h0;
      ack_due <= 1'b0;
      ack_drive <= 1'b0;
      special <= 1'b0;
      area <= 2'h0;
      addr_hi <= 8'h0;
      offset <= 6'h0;
      pending <= 1'b0;
      pend_cfg <= 1'b0;
      pend_lock <= 1'b0;
      cfg_data <= 8'h0;
      launch <= 1'b0;
      commit <= 1'b0;
      mem_wr <= 1'b0;
      mem_secure <= 1'b0;
      mem_addr <= 13'h0;
      mem_data <= 8'h0;
      dev_select <= `EES_SEL_RESET; // RL8
      soft_write_protect <= `EES_SWP_RESET;
      secure_locked <= 1'b0;
    end
    else
    begin
      launch <= 1'b0;
      commit <= 1'b0;
      mem_wr <= 1'b0;
      if (start_cond)
      begin
        state <= ST_DEVADDR; // RL5
        bit_cnt <= 4'h0;
        ack_drive <= 1'b0;
        ack_due <= 1'b0;
      end
      else if (stop_cond)
      begin
        state <= ST_IDLE;
        ack_drive <= 1'b0;
        // Nothing loaded leaves the timer alone, so an
        // address-only poll never starts a write cycle
        if (pending)
        begin
          // Commit the loaded bytes in one internal cycle
          launch <= 1'b1; // RL12 RL18
          commit <= 1'b1; // RL16
          pending <= 1'b0;
          pend_lock <= 1'b0;
          pend_cfg <= 1'b0;
          if (pend_lock)
            secure_locked <= 1'b1; // RL21
          if (pend_cfg)
          begin // RL24 RL25
            // Select bits move only while unprotected; the protect
            // bit follows the data, so it can be set and cleared
            if (!soft_write_protect)
              dev_select <= cfg_data[`EES_CFG_SEL_HI:`EES_CFG_SEL_LO];
            soft_write_protect <= cfg_data[`EES_CFG_SWP];
          end
        end
      end
      else if (state != ST_IDLE)
      begin
        if (scl_fall)
        begin
          // Drive or release only while SCL is low
          if (in_ack_slot)
            ack_drive <= ack_due; // RL2 RL9
          else if (in_done_slot)
          begin
            // Ninth clock over: let go and start the next byte
            ack_drive <= 1'b0; // RL11
            bit_cnt <= 4'h0;
            ack_due <= 1'b0;
          end
        end
        // The ninth rise carries the acknowledge, not a data bit
        if (scl_rise && in_ack_slot)
          bit_cnt <= `EES_BITS_DONE;
        if (scl_rise && !in_ack_slot && !in_done_slot)
        begin
          shift <= byte_in;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == `EES_BITS_LAST)
          begin
            case (state)
              ST_DEVADDR:
              begin
                // RL7
                // A busy part stays silent on its own address;
                // that silence is what acknowledge polling waits for
                if ((byte_in[7:4] == `EES_PREFIX_MAIN
                    || byte_in[7:4] == `EES_PREFIX_SPECIAL)
                    && byte_in[3:1] == dev_select && !busy)
                begin
                  ack_due <= 1'b1; // RL9 RL13 RL14
                  special <= byte_in[4];
                  state <= byte_in[0] ? ST_READ : ST_ADDR_HI;
                end
                else
                  state <= ST_IDLE;
              end
              ST_ADDR_HI:
              begin
                addr_hi <= byte_in;
                area <= byte_in[`EES_AREA_HI:`EES_AREA_LO]; // RL19
                state <= ST_ADDR_LO;
                ack_due <= 1'b1;
              end
              ST_ADDR_LO:
              begin
                // Refusal waits for the low byte, though allowed depends only on the prefix,
                // the high byte's area bits and the protect and lock flags
                offset <= special ? byte_in[5:0] : {1'b0, byte_in[4:0]}; // RL20
                if (!special)
                  mem_addr <= {addr_hi[4:0], byte_in[7:5], 5'h0}; // RL17
                ack_due <= allowed; // RL10 RL22
                state <= allowed ? ST_DATA : ST_IDLE;
              end
              ST_DATA:
              begin
                ack_due <= 1'b1; // RL10
                mem_data <= byte_in;
                if (special && area == `EES_AREA_CFG)
                begin
                  cfg_data <= byte_in;
                  pend_cfg <= 1'b1;
                  pending <= 1'b1;
                end
                else if (special && area == `EES_AREA_LOCK)
                begin
                  if (byte_in == `EES_LOCK_DATA)
                  begin
                    pend_lock <= 1'b1; // RL21
                    pending <= 1'b1;
                  end
                end
                else
                begin
                  mem_wr <= 1'b1;
                  mem_secure <= special;
                  // Secure offsets are six bits wide, main ones five
                  if (special)
                    mem_addr <= {7'h0, offset};
                  else
                    mem_addr <= {mem_addr[12:5], offset[4:0]};
                  pending <= 1'b1;
                  // Counter wraps inside the page
                  if (special)
                    offset <= offset + 6'h1; // RL18
                  else
                    offset <= {1'b0, offset[4:0] + 5'h1}; // RL17 RL18
                end
              end
              default:
                state <= ST_IDLE; // Reads not served here
            endcase
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** tb/ees_chk.sv ***
// Assertion checker for the EEPROM slave
`timescale 1ns/100ps
`default_nettype none
module ees_chk
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus clock pin
  input wire logic scl_in,
  // Watched outputs
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic mem_wr,
  input wire logic mem_secure,
  input wire logic [12:0] mem_addr,
  input wire logic commit,
  input wire logic busy,
  input wire logic [2:0] dev_select,
  input wire logic soft_write_protect,
  input wire logic secure_locked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_clear: assert property ($fell(rst) |->
    dev_select == 3'h0 && !soft_write_protect && !secure_locked && !busy)
    else $error("outputs not clear after reset");
  a_drive_low: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("data driven high");
  a_ack_hold: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("ack too short");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while clock high");
  a_commit_busy: assert property (commit |-> ##[0:2] busy)
    else $error("commit without busy");
  a_busy_quiet: assert property (busy |-> !mem_wr && !$rose(sda_oe))
    else $error("activity while busy");
  a_wr_pulse: assert property (mem_wr |=> !mem_wr)
    else $error("write pulse too long");
  a_sec_range: assert property (mem_wr && mem_secure |-> mem_addr[12:6] == 7'h0)
    else $error("secure offset out of range");
  a_lock_block: assert property (secure_locked |-> !(mem_wr && mem_secure))
    else $error("write to locked page");
  a_swp_block: assert property (soft_write_protect |-> !mem_wr)
    else $error("write while protected");
endmodule
bind ees_slave ees_chk u_chk (.*);
`default_nettype wire

// *** tb/ees_mst.sv ***
// Two-wire bus master model
`timescale 1ns/100ps
`default_nettype none
module ees_mst
(
  // Clock
  input wire logic sys_clk,
  // Bus
  input wire logic sda_bus,
  output var logic scl = 1'b1,
  output var logic sda = 1'b1
);
  task automatic put(input logic s, input logic d, input int n);
    scl <= s;
    sda <= d;
    repeat (n) @(posedge sys_clk);
  endtask
  // Bytes leave MSB first from the top of v; long ack tail lets the slave let go
  task automatic xfer(input logic [47:0] v, input int n, output logic [5:0] ak);
    ak = 6'h0;
    put(1'b1, 1'b1, 4);
    put(1'b1, 1'b0, 4);
    put(1'b0, 1'b0, 2);
    for (int i = 47; i > 47 - 8 * n; i--)
    begin
      put(1'b0, v[i], 2);
      put(1'b1, v[i], 4);
      put(1'b0, v[i], 2);
      if (i % 8 == 0)
      begin
        put(1'b0, 1'b1, 2);
        put(1'b1, 1'b1, 2);
        @(negedge sys_clk);
        ak[5 - i / 8] = !sda_bus;
        put(1'b1, 1'b1, 2);
        put(1'b0, 1'b1, 4);
      end
    end
    put(1'b0, 1'b0, 2);
    put(1'b1, 1'b0, 4);
    put(1'b1, 1'b1, 8);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking testbench for the EEPROM slave write path
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic scl_in, m_sda, sda_out, sda_oe, mem_wr, mem_secure, commit, busy;
  logic soft_write_protect, secure_locked;
  logic [12:0] mem_addr;
  logic [7:0] mem_data;
  logic [2:0] dev_select;
  logic [5:0] ak;
  logic [21:0] wq[$];
  int errors = 0;
  int checked = 0;
  int commits = 0;
  // Open-drain data line with pull-up
  wire logic sda_in = m_sda & !(sda_oe & !sda_out);
  always #25 sys_clk = ~sys_clk;
  ees_slave #(.WRITE_CYCLES(400)) i_dut (.*);
  ees_mst i_mst (.sys_clk, .sda_bus(sda_in), .scl(scl_in), .sda(m_sda));
  always @(posedge sys_clk)
  begin
    if (mem_wr === 1'b1)
      wq.push_back({mem_secure, mem_addr, mem_data});
    if (commit === 1'b1)
      commits++;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [47:0] v, input int n);
    wq.delete();
    i_mst.xfer(v, n, ak);
  endtask
  // Poll-free wait, as after a configuration write
  task automatic idle;
    for (int i = 0; i < 500 && busy !== 1'b0; i++)
      @(posedge sys_clk);
    cmp(busy, 0);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_byte;
    cmd(48'ha0_12_34_5a_00_00, 4);
    cmp(ak, 6'h0f);
    cmp(commits, 1);
    cmp(wq[0], {1'b0, 13'h1234, 8'h5a});
    cmp(busy, 1);
    cmd(48'ha0_00_00_00_00_00, 1);
    cmp(ak[0], 0);
    idle;
    cmd(48'ha0_00_00_00_00_00, 1);
    cmp(ak[0], 1);
    idle;
    cmd(48'ha1_00_00_00_00_00, 1);
    cmp(ak[0], 1);
  endtask
  task automatic t_wrap;
    cmd(48'ha0_00_7f_11_22_33, 6);
    cmp(wq.size(), 3);
    cmp(wq[1], {1'b0, 13'h0060, 8'h22});
    cmp(wq[2][20:8], 13'h0061);
    idle;
  endtask
  task automatic t_sec;
    cmd(48'hb0_f9_ff_44_55_00, 5);
    cmp(wq[0], {1'b1, 13'h003f, 8'h44});
    cmp(wq[1], {1'b1, 13'h0000, 8'h55});
    idle;
    cmd(48'hb0_02_00_12_00_00, 4);
    cmp(ak[3:2], 0);
    cmp(wq.size(), 0);
  endtask
  task automatic t_lock;
    cmd(48'hb0_04_00_ff_00_00, 4);
    idle;
    cmp(secure_locked, 1);
    cmd(48'hb0_00_00_66_00_00, 4);
    cmp(wq.size(), 0);
    cmp(ak[3:0] == 4'hf, 0);
    cmp(commits, 4);
    idle;
  endtask
  task automatic t_cfg;
    cmd(48'hb0_06_00_a2_00_00, 4);
    idle;
    cmp({dev_select, soft_write_protect}, 4'hb);
    cmd(48'haa_00_00_77_00_00, 4);
    cmp(wq.size(), 0);
    idle;
    cmd(48'hba_06_00_00_00_00, 4);
    idle;
    cmp({dev_select, soft_write_protect}, 4'ha);
    cmd(48'ha0_00_00_00_00_00, 1);
    cmp(ak[0], 0);
    cmp(commits, 6);
  endtask
  task automatic close_out;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmp({dev_select, soft_write_protect, secure_locked, busy}, 0);
    t_byte;
    t_wrap;
    t_sec;
    t_lock;
    t_cfg;
    close_out;
  end
  initial
  begin
    #1000000;
    errors++;
    close_out;
  end
endmodule
`default_nettype wire
